// ---- src/ebpin_params.svh ----
// width, reset and mode constants for the expansion bus pin interface
`ifndef EBPIN_PARAMS_SVH
`define EBPIN_PARAMS_SVH
`define EBPIN_ADDR_W      24
`define EBPIN_STRAP_RESET 24'hffffff
`define EBPIN_ADDR_RESET  24'h000000
`define EBPIN_MODE_STROBE 2'h0
`define EBPIN_MODE_SYNC   2'h1
`define EBPIN_MODE_HOST   2'h2
`define EBPIN_MODE_SRAM   2'h3
`endif

// ---- src/ebpin_pkg.sv ----
// types for the expansion bus pin interface
package ebpin_pkg;
  typedef enum logic [1:0] {
    EBPIN_STROBE = 2'h0,
    EBPIN_SYNC   = 2'h1,
    EBPIN_HOST   = 2'h2,
    EBPIN_SRAM   = 2'h3
  } ebpin_mode_type;
  typedef enum logic [1:0] {
    EBPIN_IDLE  = 2'h0,
    EBPIN_ADDR  = 2'h1,
    EBPIN_DATA  = 2'h2,
    EBPIN_FREE  = 2'h3
  } ebpin_state_type;
endpackage : ebpin_pkg

// ---- src/ebpin_sync.sv ----
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module ebpin_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);
  logic [W-1:0] meta_q;
  always_ff @(posedge mclk) begin
    if (rst) begin
      meta_q <= '0;
      dout   <= '0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule // ebpin_sync
`default_nettype wire

// ---- src/ebpin_core.sv ----
// expansion bus pin control: strobes, address drive, straps
// Functional notes
// [R1] all pins timed on bus clock
// [R2] latch strobe marks multiplexed address phase
// [R3] latch strobe is advance or load
// [R4] latch strobe used on every outbound transfer
// [R5] address out outbound, in inbound
// [R6] straps captured from address during reset
// [R7] pull-ups off after lock, drive by grant
// [R8] address driven except reset or external grant
// [R9] write pin role set by mode
// [R10] write pin input for inbound
// [R11] read pin role set by mode
// [R12] read pin input for inbound
// [R13] strobes released during external grant
// [R14] latch strobe floats during external grant
`timescale 1ns/1ps
`default_nettype none
`include "ebpin_params.svh"
module ebpin_core (
  input  wire logic                    mclk,
  input  wire logic                    rst,
  input  wire logic                    pll_lock,
  input  wire logic                    ext_grant,
  input  wire logic [1:0]              cycle_mode,
  input  wire logic                    xfer_req,
  input  wire logic                    xfer_write,
  input  wire logic [`EBPIN_ADDR_W-1:0] xfer_addr,
  output logic                         xfer_ack,
  output logic [`EBPIN_ADDR_W-1:0]     strap_cfg,
  output logic                         strap_valid,
  output logic                         pullup_en,
  output logic                         addr_latch_strobe,
  output logic                         addr_latch_strobe_oe,
  input  wire logic [`EBPIN_ADDR_W-1:0] bus_addr_lines_in,
  output logic [`EBPIN_ADDR_W-1:0]     bus_addr_lines_out,
  output logic                         bus_addr_lines_oe,
  input  wire logic                    bus_write_strobe_n_in,
  output logic                         bus_write_strobe_n_out,
  output logic                         bus_write_strobe_n_oe,
  input  wire logic                    bus_read_strobe_n_in,
  output logic                         bus_read_strobe_n_out,
  output logic                         bus_read_strobe_n_oe,
  output logic [`EBPIN_ADDR_W-1:0]     inb_addr,
  output logic                         inb_write_n,
  output logic                         inb_read_n
);
  ebpin_pkg::ebpin_state_type state_q;
  logic                        lock_s;
  logic                        grant_s;
  logic                        wr_in_s;
  logic                        rd_in_s;
  logic [`EBPIN_ADDR_W-1:0]    addr_in_s;
  logic                        write_q;
  logic [1:0]                  mode_q;
  logic [`EBPIN_ADDR_W-1:0]    addr_q;
  logic                        ale_q;
  logic                        wr_q;
  logic                        rd_q;
  logic                        rst_seen_q;

  // [R1] pins sampled on bus clock
  ebpin_sync #(.W(2)) u_ctl_sync (
    .mclk (mclk),
    .rst  (rst),
    .din  ({pll_lock, ext_grant}),
    .dout ({lock_s, grant_s})
  );
  ebpin_sync #(.W(`EBPIN_ADDR_W + 2)) u_pin_sync (
    .mclk (mclk),
    .rst  (1'b0),
    .din  ({bus_write_strobe_n_in, bus_read_strobe_n_in, bus_addr_lines_in}),
    .dout ({wr_in_s, rd_in_s, addr_in_s})
  );

  // [R6] straps latched while reset
  always_ff @(posedge mclk) begin
    rst_seen_q <= rst;
    if (rst) begin
      strap_cfg   <= addr_in_s;
      strap_valid <= 1'b0;
    end else if (rst_seen_q) begin
      strap_valid <= 1'b1;
    end
  end

  // [R7] pull-ups off on lock
  always_ff @(posedge mclk) begin
    if (rst) begin
      pullup_en <= 1'b1;
    end else if (lock_s) begin
      pullup_en <= 1'b0;
    end
  end

  // outbound sequencer: address phase, data phase, back to idle
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= ebpin_pkg::EBPIN_IDLE;
      write_q <= 1'b0;
      mode_q  <= `EBPIN_MODE_STROBE;
      addr_q  <= `EBPIN_ADDR_RESET;
    end else begin
      case (state_q)
        ebpin_pkg::EBPIN_IDLE: begin
          if (grant_s) begin
            state_q <= ebpin_pkg::EBPIN_FREE;
          end else if (xfer_req) begin
            state_q <= ebpin_pkg::EBPIN_ADDR;
            write_q <= xfer_write;
            mode_q  <= cycle_mode;
            addr_q  <= xfer_addr;
          end
        end
        ebpin_pkg::EBPIN_ADDR: state_q <= ebpin_pkg::EBPIN_DATA;
        ebpin_pkg::EBPIN_DATA: state_q <= ebpin_pkg::EBPIN_IDLE;
        ebpin_pkg::EBPIN_FREE: begin
          if (!grant_s) begin
            state_q <= ebpin_pkg::EBPIN_IDLE;
          end
        end
        default: state_q <= ebpin_pkg::EBPIN_IDLE;
      endcase
    end
  end

  assign xfer_ack = (state_q == ebpin_pkg::EBPIN_DATA);

  // [R2] [R3] [R4] latch strobe per mode
  always_ff @(posedge mclk) begin
    if (rst) begin
      ale_q <= 1'b0;
    end else if (state_q == ebpin_pkg::EBPIN_IDLE && xfer_req && !grant_s) begin
      // sram load strobe is active low, others active high
      ale_q <= (cycle_mode == `EBPIN_MODE_SRAM) ? 1'b0 : 1'b1;
    end else begin
      ale_q <= (mode_q == `EBPIN_MODE_SRAM && state_q == ebpin_pkg::EBPIN_IDLE)
               ? 1'b1 : (mode_q == `EBPIN_MODE_SRAM);
    end
  end

  // [R9] [R11] strobe roles per mode
  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_q <= 1'b1;
      rd_q <= 1'b1;
    end else if (state_q == ebpin_pkg::EBPIN_ADDR) begin
      case (mode_q)
        `EBPIN_MODE_STROBE: begin
          wr_q <= !write_q;
          rd_q <= write_q;
        end
        `EBPIN_MODE_SYNC, `EBPIN_MODE_HOST: begin
          wr_q <= 1'b0;
          rd_q <= !write_q;
        end
        `EBPIN_MODE_SRAM: begin
          wr_q <= !write_q;
          rd_q <= write_q;
        end
        default: begin
          wr_q <= 1'b1;
          rd_q <= 1'b1;
        end
      endcase
    end else begin
      wr_q <= 1'b1;
      rd_q <= 1'b1;
    end
  end

  // [R8] [R5] address drive window
  assign bus_addr_lines_out = addr_q;
  assign bus_addr_lines_oe  = !rst && !grant_s;
  // [R13] strobes released on grant
  assign bus_write_strobe_n_out = wr_q;
  assign bus_read_strobe_n_out  = rd_q;
  assign bus_write_strobe_n_oe  = !grant_s;
  assign bus_read_strobe_n_oe   = !grant_s;
  // [R14] latch strobe floats on grant
  assign addr_latch_strobe    = ale_q;
  assign addr_latch_strobe_oe = !grant_s;

  // [R10] [R12] inbound pins captured
  always_ff @(posedge mclk) begin
    if (rst) begin
      inb_addr    <= `EBPIN_ADDR_RESET;
      inb_write_n <= 1'b1;
      inb_read_n  <= 1'b1;
    end else if (state_q == ebpin_pkg::EBPIN_FREE) begin
      inb_addr    <= addr_in_s;
      inb_write_n <= wr_in_s;
      inb_read_n  <= rd_in_s;
    end else begin
      inb_write_n <= 1'b1;
      inb_read_n  <= 1'b1;
    end
  end

  property p_addr_off_grant;
    @(posedge mclk) disable iff (rst) grant_s |-> !bus_addr_lines_oe;
  endproperty
  a_addr_off_grant: assert property (p_addr_off_grant) else $error("addr driven in grant"); // [R8]
  property p_strobe_off;
    @(posedge mclk) disable iff (rst)
      grant_s |-> !bus_write_strobe_n_oe && !bus_read_strobe_n_oe && !addr_latch_strobe_oe;
  endproperty
  a_strobe_off: assert property (p_strobe_off) else $error("strobe driven in grant"); // [R13]
  property p_ale_phase;
    @(posedge mclk) disable iff (rst)
      (state_q == ebpin_pkg::EBPIN_IDLE && xfer_req && !grant_s &&
       cycle_mode != `EBPIN_MODE_SRAM)
      |=> addr_latch_strobe;
  endproperty
  a_ale_phase: assert property (p_ale_phase) else $error("no latch strobe"); // [R4]
  property p_ack_seq;
    @(posedge mclk) disable iff (rst)
      (state_q == ebpin_pkg::EBPIN_IDLE && xfer_req && !grant_s) |=> ##1 xfer_ack;
  endproperty
  a_ack_seq: assert property (p_ack_seq) else $error("ack late"); // [R2]
  property p_pull_lock;
    @(posedge mclk) disable iff (rst) lock_s |=> !pullup_en;
  endproperty
  a_pull_lock: assert property (p_pull_lock) else $error("pullup on after lock"); // [R7]
  property p_strap;
    // checked at release: the pin synchroniser holds unknowns early in reset
    @(posedge mclk) $fell(rst) |-> strap_cfg == $past(addr_in_s);
  endproperty
  a_strap: assert property (p_strap) else $error("strap missed"); // [R6]
  property p_rd_strobe;
    @(posedge mclk) disable iff (rst)
      (state_q == ebpin_pkg::EBPIN_ADDR && mode_q == 2'h0 && !write_q) |=> !bus_read_strobe_n_out;
  endproperty
  a_rd_strobe: assert property (p_rd_strobe) else $error("read strobe missing"); // [R11]
  property p_wr_strobe;
    @(posedge mclk) disable iff (rst)
      (state_q == ebpin_pkg::EBPIN_ADDR && mode_q == 2'h1) |=> !bus_write_strobe_n_out;
  endproperty
  a_wr_strobe: assert property (p_wr_strobe) else $error("data strobe missing"); // [R9]
endmodule // ebpin_core
`default_nettype wire

// ---- verification/ebpin_peer.sv ----
// far side: board straps and an external bus master
`timescale 1ns/1ps
`default_nettype none
module ebpin_peer (
  input  wire logic        mclk,
  input  wire logic        m_on,
  input  wire logic [23:0] strap,
  input  wire logic [23:0] m_addr,
  input  wire logic        m_wr_n,
  input  wire logic        m_rd_n,
  input  wire logic        a_oe,
  input  wire logic [23:0] a_out,
  input  wire logic        w_oe,
  input  wire logic        w_out,
  input  wire logic        r_oe,
  input  wire logic        r_out,
  output logic [23:0]      a_pin,
  output logic             w_pin,
  output logic             r_pin
);
  logic w_q;
  logic r_q;
  // master when on, else pull-downs on strap bits
  assign a_pin = a_oe ? a_out : m_on ? m_addr : strap;
  assign w_pin = w_oe ? w_out : m_on ? m_wr_n : ~w_q;
  assign r_pin = r_oe ? r_out : m_on ? m_rd_n : ~r_q;
  always_ff @(posedge mclk) begin
    w_q <= w_pin;
    r_q <= r_pin;
  end
endmodule // ebpin_peer
`default_nettype wire

// ---- verification/expansion_bus_pin_interface_test.sv ----
// self-checking bench for the expansion bus pin interface
`timescale 1ns/1ps
`default_nettype none
module expansion_bus_pin_interface_test;
  logic mclk = 0, rst = 1, pll_lock = 0, ext_grant = 0, m_on = 0;
  logic xfer_req = 0, xfer_write = 0, m_wr_n = 1, m_rd_n = 1;
  logic [1:0] cycle_mode = 0;
  logic [23:0] xfer_addr = 0, m_addr = 0;
  logic [23:0] bus_addr_lines_in, bus_addr_lines_out, strap_cfg, inb_addr;
  logic bus_write_strobe_n_in, bus_read_strobe_n_in, inb_write_n, inb_read_n;
  logic bus_write_strobe_n_out, bus_read_strobe_n_out, bus_write_strobe_n_oe;
  logic bus_read_strobe_n_oe, bus_addr_lines_oe, xfer_ack, strap_valid;
  logic pullup_en, addr_latch_strobe, addr_latch_strobe_oe;
  int mismatches = 0, num_checks = 0, cyc = 0;
  localparam logic [23:0] STRAP = 24'hfff0f5;
  always #20 mclk = ~mclk;
  ebpin_core dut_u (.mclk, .rst, .pll_lock, .ext_grant, .cycle_mode, .xfer_req,
    .xfer_write, .xfer_addr, .xfer_ack, .strap_cfg, .strap_valid, .pullup_en,
    .addr_latch_strobe, .addr_latch_strobe_oe, .bus_addr_lines_in, .bus_addr_lines_out,
    .bus_addr_lines_oe, .bus_write_strobe_n_in, .bus_write_strobe_n_out,
    .bus_write_strobe_n_oe, .bus_read_strobe_n_in, .bus_read_strobe_n_out,
    .bus_read_strobe_n_oe, .inb_addr, .inb_write_n, .inb_read_n);
  ebpin_peer peer_u (.mclk, .m_on, .strap(STRAP), .m_addr, .m_wr_n, .m_rd_n,
    .a_oe(bus_addr_lines_oe), .a_out(bus_addr_lines_out),
    .w_oe(bus_write_strobe_n_oe), .w_out(bus_write_strobe_n_out),
    .r_oe(bus_read_strobe_n_oe), .r_out(bus_read_strobe_n_out),
    .a_pin(bus_addr_lines_in), .w_pin(bus_write_strobe_n_in), .r_pin(bus_read_strobe_n_in));
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic results();
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard: whole run is well under 200 cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      mismatches++;
      results();
    end
  end
  task automatic test_reset();
    step(1);
    chk(bus_addr_lines_oe, 0);
    chk(pullup_en, 1);
    step(4);
    rst = 0;
    step(2);
    chk(strap_cfg, STRAP);
    chk(strap_valid, 1);
    chk(bus_addr_lines_oe, 1);
    pll_lock = 1;
    step(4);
    chk(pullup_en, 0);
  endtask
  task automatic xfer(input logic [1:0] m, input logic w, input logic [23:0] a);
    logic hs;
    hs = (m == 2'h1 || m == 2'h2);
    cycle_mode = m;
    xfer_write = w;
    xfer_addr = a;
    xfer_req = 1;
    step(1);
    // address phase stands in the cycle after the take edge
    xfer_req = 0;
    chk(addr_latch_strobe, m != 2'h3);
    chk(bus_addr_lines_out, a);
    chk(xfer_ack, 0);
    step(1);
    chk(xfer_ack, 1);
    chk(bus_write_strobe_n_out, hs ? 1'b0 : !w);
    chk(bus_read_strobe_n_out, hs ? !w : w);
    chk(addr_latch_strobe, m == 2'h3);
    step(1);
    chk(xfer_ack, 0);
    chk(bus_write_strobe_n_out, 1);
    chk(bus_read_strobe_n_out, 1);
  endtask
  task automatic test_grant();
    ext_grant = 1;
    m_on = 1;
    m_addr = 24'h3c5a96;
    m_wr_n = 0;
    step(3);
    xfer_req = 1;
    step(3);
    chk(bus_addr_lines_oe, 0);
    chk(addr_latch_strobe_oe, 0);
    chk(bus_write_strobe_n_oe, 0);
    chk(bus_read_strobe_n_oe, 0);
    chk(inb_addr, 24'h3c5a96);
    chk(inb_write_n, 0);
    chk(inb_read_n, 1);
    chk(xfer_ack, 0);
    xfer_req = 0;
    ext_grant = 0;
    step(4);
    m_on = 0;
    chk(bus_read_strobe_n_oe, 1);
    chk(bus_write_strobe_n_oe, 1);
    chk(addr_latch_strobe_oe, 1);
  endtask
  initial begin
    test_reset();
    for (int m = 0; m < 4; m++) begin
      for (int w = 0; w < 2; w++) begin
        xfer(2'(m), 1'(w), w ? 24'hffffff : 24'h800001);
      end
    end
    test_grant();
    xfer(2'h0, 1'b1, 24'h000000);
    results();
  end
endmodule // expansion_bus_pin_interface_test
`default_nettype wire
